// >>> ascu_defines.vh
// Register offsets, field positions, reset values and timing counts of the serial channel
`ifndef ASCU_DEFINES_VH
`define ASCU_DEFINES_VH

// ------------------------------------------------------------
// Register offsets (3-bit register select)
// ------------------------------------------------------------
`define ASCU_OFS_DATA 3'h0
`define ASCU_OFS_IEN 3'h1
`define ASCU_OFS_IID 3'h2
`define ASCU_OFS_LCTL 3'h3
`define ASCU_OFS_MCTL 3'h4
`define ASCU_OFS_LSTAT 3'h5
`define ASCU_OFS_MSTAT 3'h6
`define ASCU_OFS_SCR 3'h7

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ASCU_LC_STOP 2
`define ASCU_LC_PEN 3
`define ASCU_LC_EPS 4
`define ASCU_LC_STICK 5
`define ASCU_LC_BREAK 6
`define ASCU_LC_DIVSEL 7
`define ASCU_LS_DR 0
`define ASCU_LS_OE 1
`define ASCU_LS_PE 2
`define ASCU_LS_FE 3
`define ASCU_LS_BI 4
`define ASCU_LS_TX_HOLDING_EMPTY 5
`define ASCU_LS_TX_ALL_EMPTY 6

// ------------------------------------------------------------
// Interrupt identification codes and reset values
// ------------------------------------------------------------
`define ASCU_IID_NONE 8'h01
`define ASCU_IID_LINE 2'h3
`define ASCU_IID_RXD 2'h2
`define ASCU_IID_TX_HOLDING_EMPTY 2'h1
`define ASCU_IID_MODEM 2'h0
`define ASCU_LSTAT_RST 8'h60
`define ASCU_DIV_INIT 16'h0001
`define ASCU_LCTL_INIT 8'h03

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define ASCU_OVS 5'h10
`define ASCU_MID_START 4'h7
`define ASCU_RST_HOLD_NS 500
`define ASCU_CLK_NS 50
`define ASCU_RST_HOLD_CYC ((`ASCU_RST_HOLD_NS + `ASCU_CLK_NS - 1) / `ASCU_CLK_NS)

`endif

// >>> ascu_channel.v
// Asynchronous serial channel: host registers, interrupt priority, baud generator, transmitter, receiver
// Contract
// - Identification bit 0 is low while an enabled interrupt pends, else high.
// - Identification reports only the highest-priority pending interrupt.
// - Priority line status 11, rx data 10, tx empty 01, modem 00.
// - Tx-empty interrupt clears on identification read of it or holding write.
// - Identification bits 7:3 always read zero.
// - Enable bits 0..3 gate rx data, tx empty, line status, modem status.
// - All enables clear suppress identification and irq output; flags keep updating.
// - Enable bits 7:4 held zero.
// - Host writes holding only when empty (the channel takes a holding write at any time and overwrites it); flag sets on move to shifter.
// - Idle both empty flags high; write clears holding-empty; all-empty low during character.
// - Holding moves only when shifter empty; all-empty sets after last bit.
// - Falling serial input edge starts count to start-bit middle at 16x.
// - Start accepted only if input still low mid-bit, else resume searching.
// - Line control sets length, stop bits, parity enable and polarity both ways; the receiver checks one stop bit whatever the stop select.
// - Reading receive buffer clears data-ready.
// - New character into unread buffer sets overrun.
// - With parity on, check parity bit before stop; mismatch sets parity error.
// - Stop bit sampled low sets framing error.
// - Baud generator divides external clock by 16-bit divisor; 1 is fastest.
// - Generator output is 16x bit rate; writing a latch reloads counter.
// - Reset held 500 ns clears counters, line status except empties, modem control.
// - Reset leaves line control, divisors, receive buffer, holding register unchanged.
// - Enabling tx-empty interrupt after reset raises it at once.
module ascu_channel #(
    parameter DATA_W = 8
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Host parallel bus
    input wire host_cs,
    input wire host_rd,
    input wire host_wr,
    input wire [2:0] host_addr,
    input wire [DATA_W-1:0] host_data_bus_in,
    output reg [DATA_W-1:0] host_data_bus_out,
    output reg host_data_bus_oe,
    // Baud source
    input wire ext_clock_in,
    // Serial line and modem
    input wire serial_in,
    output reg serial_out,
    input wire cts_n,
    input wire dsr_n,
    input wire ri_n,
    input wire dcd_n,
    output reg rts_n,
    output reg dtr_n,
    output reg out1_n,
    output reg out2_n,
    // Interrupt
    output reg irq_output
);
`include "ascu_defines.vh"

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [7:0] line_control_q, modem_control_q, scratch_q, tx_holding_reg_q, rx_buffer_reg_q;
    reg [7:0] divisor_low_q, divisor_high_q;
    reg [3:0] interrupt_enable_q;
    reg dr_q, oe_q, pe_q, fe_q, bi_q, tx_holding_empty_q, tx_all_empty_q, tx_holding_empty_irq_q;
    reg [3:0] mdelta_q;
    reg [3:0] mline_q;
    reg ext_q, ext_prev_q;
    reg [15:0] baud_cnt_q;
    reg tick_q;

    wire rd_now = host_cs & host_rd;
    wire wr_now = host_cs & host_wr;
    wire divsel = line_control_q[`ASCU_LC_DIVSEL];
    wire wr_thr = wr_now & (host_addr == `ASCU_OFS_DATA) & ~divsel;
    wire rd_rbr = rd_now & (host_addr == `ASCU_OFS_DATA) & ~divsel;
    wire wr_div = wr_now & (host_addr[2:1] == 2'h0) & divsel;
    wire rd_lsr = rd_now & (host_addr == `ASCU_OFS_LSTAT);
    wire rd_msr = rd_now & (host_addr == `ASCU_OFS_MSTAT);
    wire rd_iid = rd_now & (host_addr == `ASCU_OFS_IID);

    // Data bits per character: word length code plus 5
    function [3:0] ascu_data_bits;
        input [1:0] wl;
        ascu_data_bits = {2'h0, wl} + 4'h5;
    endfunction

    // ------------------------------------------------------------
    // Baud generator
    // ------------------------------------------------------------
    // The external clock is sampled; its rising edges advance the divider
    wire ext_rise = ext_q & ~ext_prev_q;
    wire [15:0] divisor = {divisor_high_q, divisor_low_q};
    always @(posedge sys_clk) begin
        ext_q <= ext_clock_in;
        ext_prev_q <= ext_q;
        tick_q <= 1'b0;
        if (!rst_n) begin
            baud_cnt_q <= 16'h0001;
        end else if (wr_div) begin
            baud_cnt_q <= 16'h0001;
        end else if (ext_rise) begin
            if (baud_cnt_q <= 16'h0001) begin
                baud_cnt_q <= divisor;
                tick_q <= 1'b1;
            end else begin
                baud_cnt_q <= baud_cnt_q - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    localparam TX_IDLE = 2'h0, TX_START = 2'h1, TX_BITS = 2'h2, TX_STOP = 2'h3;
    reg [1:0] tx_st_q;
    reg [3:0] tx_sub_q;
    reg [3:0] tx_bit_q;
    reg [9:0] tx_shift_q;
    reg [4:0] tx_stop_len_q;
    wire [3:0] nbits = ascu_data_bits(line_control_q[1:0]);
    wire tx_par = line_control_q[`ASCU_LC_STICK] ? ~line_control_q[`ASCU_LC_EPS] :
                  (^(tx_holding_reg_q & (8'hFF >> (4'h8 - nbits)))) ^ ~line_control_q[`ASCU_LC_EPS];
    wire [3:0] tx_total = nbits + {3'h0, line_control_q[`ASCU_LC_PEN]};
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_st_q <= TX_IDLE;
            tx_sub_q <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_shift_q <= 10'h3FF;
            tx_stop_len_q <= 5'h0;
            tx_holding_empty_q <= 1'b1;
            tx_all_empty_q <= 1'b1;
            serial_out <= 1'b1;
        end else begin
            if (wr_thr)
                tx_holding_empty_q <= 1'b0;
            case (tx_st_q)
                TX_IDLE: begin
                    serial_out <= 1'b1;
                    if (!tx_holding_empty_q && tick_q) begin
                        // Data right-justified, parity just above it, stop ones fill the rest
                        tx_shift_q <= {2'h0, tx_holding_reg_q & (8'hFF >> (4'h8 - nbits))} |
                                      ({9'h000, tx_par} << nbits) |
                                      (10'h3FF << tx_total);
                        tx_st_q <= TX_START;
                        tx_sub_q <= 4'h0;
                        tx_all_empty_q <= 1'b0;
                        tx_holding_empty_q <= 1'b1;
                    end
                end
                TX_START: begin
                    serial_out <= 1'b0;
                    if (tick_q) begin
                        tx_sub_q <= tx_sub_q + 4'h1;
                        if (tx_sub_q == 4'hF) begin
                            tx_st_q <= TX_BITS;
                            tx_bit_q <= 4'h0;
                        end
                    end
                end
                TX_BITS: begin
                    serial_out <= tx_shift_q[0];
                    if (tick_q) begin
                        tx_sub_q <= tx_sub_q + 4'h1;
                        if (tx_sub_q == 4'hF) begin
                            tx_shift_q <= {1'b1, tx_shift_q[9:1]};
                            tx_bit_q <= tx_bit_q + 4'h1;
                            if (tx_bit_q == tx_total - 4'h1) begin
                                tx_st_q <= TX_STOP;
                                // 1 stop bit; with stop select set, 1.5 for 5-bit characters, else 31 ticks
                                tx_stop_len_q <= !line_control_q[`ASCU_LC_STOP] ? 5'h10 :
                                                 (line_control_q[1:0] == 2'h0 ? 5'h18 : 5'h1F);
                            end
                        end
                    end
                end
                TX_STOP: begin
                    serial_out <= 1'b1;
                    if (tick_q) begin
                        tx_stop_len_q <= tx_stop_len_q - 5'h1;
                        if (tx_stop_len_q == 5'h1) begin
                            tx_st_q <= TX_IDLE;
                            tx_all_empty_q <= tx_holding_empty_q & ~wr_thr;
                        end
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
            if (line_control_q[`ASCU_LC_BREAK])
                serial_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    localparam RX_HUNT = 2'h0, RX_START = 2'h1, RX_BITS = 2'h2;
    reg [1:0] rx_st_q;
    reg [3:0] rx_sub_q;
    reg [3:0] rx_bit_q;
    reg [9:0] rx_shifter_q;
    reg rx_s1_q, rx_s2_q, rx_prev_q;
    wire rx_line = modem_control_q[4] ? serial_out : rx_s2_q;
    wire [3:0] rx_total = tx_total + 4'h1;
    wire [9:0] rx_full = {rx_line, rx_shifter_q[9:1]} >> (4'hA - rx_total);
    wire [7:0] rx_data = rx_full[7:0] & (8'hFF >> (4'h8 - nbits));
    wire rx_par_bit = rx_full[nbits];
    wire rx_par_ok = line_control_q[`ASCU_LC_STICK] ? (rx_par_bit == ~line_control_q[`ASCU_LC_EPS]) :
                     ((^rx_data) ^ rx_par_bit ^ ~line_control_q[`ASCU_LC_EPS]) == 1'b0;
    wire rx_done = (rx_st_q == RX_BITS) & tick_q & (rx_sub_q == 4'hF) & (rx_bit_q == rx_total - 4'h1);
    always @(posedge sys_clk) begin
        rx_s1_q <= serial_in;
        rx_s2_q <= rx_s1_q;
        if (!rst_n) begin
            rx_st_q <= RX_HUNT;
            rx_sub_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_prev_q <= 1'b1;
            rx_shifter_q <= 10'h0;
        end else begin
            rx_prev_q <= rx_line;
            case (rx_st_q)
                RX_HUNT: if (rx_prev_q && !rx_line) begin
                    rx_st_q <= RX_START;
                    rx_sub_q <= 4'h0;
                end
                RX_START: if (tick_q) begin
                    rx_sub_q <= rx_sub_q + 4'h1;
                    if (rx_sub_q == `ASCU_MID_START) begin
                        rx_sub_q <= 4'h0;
                        rx_bit_q <= 4'h0;
                        rx_st_q <= rx_line ? RX_HUNT : RX_BITS;
                    end
                end
                RX_BITS: if (tick_q) begin
                    rx_sub_q <= rx_sub_q + 4'h1;
                    if (rx_sub_q == 4'hF) begin
                        rx_shifter_q <= {rx_line, rx_shifter_q[9:1]};
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_done)
                            rx_st_q <= RX_HUNT;
                    end
                end
                default: rx_st_q <= RX_HUNT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Line and modem status
    // ------------------------------------------------------------
    // Sets win over read-clears so no event is lost
    wire [3:0] mline_now = modem_control_q[4] ?
        {modem_control_q[3], modem_control_q[2], modem_control_q[0], modem_control_q[1]} :
        {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
    wire [3:0] mchg = {mline_now[3] ^ mline_q[3], mline_q[2] & ~mline_now[2],
                       mline_now[1] ^ mline_q[1], mline_now[0] ^ mline_q[0]};
    always @(posedge sys_clk) begin
        if (rx_done)
            rx_buffer_reg_q <= rx_data;
        if (wr_thr)
            tx_holding_reg_q <= host_data_bus_in;
        if (!rst_n) begin
            dr_q <= 1'b0;
            oe_q <= 1'b0;
            pe_q <= 1'b0;
            fe_q <= 1'b0;
            bi_q <= 1'b0;
            mdelta_q <= 4'h0;
            mline_q <= 4'h0;
        end else begin
            mline_q <= mline_now;
            dr_q <= rx_done | (dr_q & ~rd_rbr);
            oe_q <= (rx_done & dr_q & ~rd_rbr) | (oe_q & ~rd_lsr);
            pe_q <= (rx_done & line_control_q[`ASCU_LC_PEN] & ~rx_par_ok) | (pe_q & ~rd_lsr);
            fe_q <= (rx_done & ~rx_line) | (fe_q & ~rd_lsr);
            bi_q <= (rx_done & ~rx_line & (rx_data == 8'h00)) | (bi_q & ~rd_lsr);
            mdelta_q <= mchg | (mdelta_q & {4{~rd_msr}});
        end
    end

    // ------------------------------------------------------------
    // Interrupt priority
    // ------------------------------------------------------------
    wire line_pend = interrupt_enable_q[2] & (oe_q | pe_q | fe_q | bi_q);
    wire rxd_pend = interrupt_enable_q[0] & dr_q;
    wire tx_holding_empty_pend = interrupt_enable_q[1] & tx_holding_empty_irq_q;
    wire mod_pend = interrupt_enable_q[3] & (|mdelta_q);
    reg [7:0] iid;
    always @* begin
        iid = `ASCU_IID_NONE;
        if (line_pend)
            iid = {5'h0, `ASCU_IID_LINE, 1'b0};
        else if (rxd_pend)
            iid = {5'h0, `ASCU_IID_RXD, 1'b0};
        else if (tx_holding_empty_pend)
            iid = {5'h0, `ASCU_IID_TX_HOLDING_EMPTY, 1'b0};
        else if (mod_pend)
            iid = {5'h0, `ASCU_IID_MODEM, 1'b0};
    end
    reg tx_holding_empty_prev_q;
    wire ien_wr = wr_now & (host_addr == `ASCU_OFS_IEN) & ~divsel;

    // ------------------------------------------------------------
    // Host registers
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (wr_now && host_addr == `ASCU_OFS_LCTL)
            line_control_q <= host_data_bus_in;
        if (wr_div && !host_addr[0])
            divisor_low_q <= host_data_bus_in;
        if (wr_div && host_addr[0])
            divisor_high_q <= host_data_bus_in;
        if (wr_now && host_addr == `ASCU_OFS_SCR)
            scratch_q <= host_data_bus_in;
        if (!rst_n) begin
            modem_control_q <= 8'h00;
            interrupt_enable_q <= 4'h0;
            tx_holding_empty_irq_q <= 1'b1;
            tx_holding_empty_prev_q <= 1'b1;
            host_data_bus_out <= 8'h00;
            host_data_bus_oe <= 1'b0;
            irq_output <= 1'b0;
            {out2_n, out1_n, rts_n, dtr_n} <= 4'hF;
        end else begin
            if (wr_now && host_addr == `ASCU_OFS_MCTL)
                modem_control_q <= host_data_bus_in & 8'h1F;
            if (ien_wr)
                interrupt_enable_q <= host_data_bus_in[3:0];
            tx_holding_empty_prev_q <= tx_holding_empty_q;
            if (tx_holding_empty_q && !tx_holding_empty_prev_q)
                tx_holding_empty_irq_q <= 1'b1;
            else if (wr_thr || (rd_iid && iid[3:1] == {1'b0, `ASCU_IID_TX_HOLDING_EMPTY}))
                tx_holding_empty_irq_q <= 1'b0;
            irq_output <= ~iid[0];
            {out2_n, out1_n, rts_n, dtr_n} <= ~modem_control_q[3:0] | {4{modem_control_q[4]}};
            host_data_bus_oe <= rd_now;
            case (host_addr)
                `ASCU_OFS_DATA: host_data_bus_out <= divsel ? divisor_low_q : rx_buffer_reg_q;
                `ASCU_OFS_IEN: host_data_bus_out <= divsel ? divisor_high_q : {4'h0, interrupt_enable_q};
                `ASCU_OFS_IID: host_data_bus_out <= iid;
                `ASCU_OFS_LCTL: host_data_bus_out <= line_control_q;
                `ASCU_OFS_MCTL: host_data_bus_out <= modem_control_q;
                `ASCU_OFS_LSTAT: host_data_bus_out <= {1'b0, tx_all_empty_q, tx_holding_empty_q,
                                                        bi_q, fe_q, pe_q, oe_q, dr_q};
                `ASCU_OFS_MSTAT: host_data_bus_out <= {mline_q, mdelta_q};
                default: host_data_bus_out <= scratch_q;
            endcase
        end
    end
endmodule // ascu_channel

// >>> ascu_channel_assertions.sv
// Port-level assertions and covers for the serial channel, bound into its top module
`include "ascu_defines.vh"
module ascu_channel_assertions #(
    parameter DATA_W = 8
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Host bus
    input wire host_cs,
    input wire host_rd,
    input wire host_wr,
    input wire [2:0] host_addr,
    input wire [DATA_W-1:0] host_data_bus_in,
    input wire [DATA_W-1:0] host_data_bus_out,
    input wire host_data_bus_oe,
    // Line, modem and interrupt
    input wire serial_out,
    input wire rts_n,
    input wire dtr_n,
    input wire irq_output
);
    timeunit 1ns;
    timeprecision 1ns;
    // Divisor select is not reset, so it is tracked from line control writes
    reg divsel_q;
    always @(posedge sys_clk)
        if (host_cs && host_wr && host_addr == `ASCU_OFS_LCTL) divsel_q <= host_data_bus_in[7];
    wire rd_any = host_cs && host_rd;
    wire rd_iid = rd_any && host_addr == `ASCU_OFS_IID;
    wire rd_lst = rd_any && host_addr == `ASCU_OFS_LSTAT;
    wire ien_off = host_cs && host_wr && host_addr == `ASCU_OFS_IEN && !divsel_q && host_data_bus_in[3:0] == 4'h0;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_reset_outputs_idle: assert property (disable iff (1'b0)
        !rst_n |=> serial_out && !irq_output && rts_n && dtr_n && !host_data_bus_oe)
        else $error("outputs not idle after reset");
    a_iid_upper_zero: assert property (rd_iid |=> host_data_bus_out[7:3] == 5'h00)
        else $error("identification upper bits not zero");
    a_iid_none_code: assert property (rd_iid |=> !host_data_bus_out[0] || host_data_bus_out[2:1] == 2'h0)
        else $error("identification shows a source with no pending flag");
    a_lstat_empty_order: assert property (rd_lst |=> !host_data_bus_out[7] && (host_data_bus_out[5] || !host_data_bus_out[6]))
        else $error("all-empty set while holding not empty");
    a_start_bit_width: assert property ($fell(serial_out) |-> !serial_out [*8])
        else $error("start bit too short");
    a_irq_masked_drop: assert property (ien_off |=> ##1 !irq_output)
        else $error("irq stays high with all enables clear");
    a_iid_read_answered: assert property (rd_iid |=> host_data_bus_oe)
        else $error("identification read not answered");
    a_bus_released: assert property (!rd_any |=> !host_data_bus_oe)
        else $error("bus driven without a read");
    c_iid_pending: cover property (rd_iid ##1 !host_data_bus_out[0]);
    c_tx_start: cover property ($fell(serial_out));
    c_overrun_seen: cover property (rd_lst ##1 host_data_bus_out[1]);
endmodule // ascu_channel_assertions

bind ascu_channel ascu_channel_assertions #(.DATA_W(DATA_W)) u_ascu_chk (
    .sys_clk, .rst_n, .host_cs, .host_rd, .host_wr, .host_addr, .host_data_bus_in,
    .host_data_bus_out, .host_data_bus_oe, .serial_out, .rts_n, .dtr_n, .irq_output
);

// >>> ascu_line_model.sv
// Far-end modem model: frames characters onto the receive line and decodes the transmit line
module ascu_line_model #(
    parameter BIT_NS = 1600
) (
    // From the channel
    input wire serial_out,
    // To the channel
    output logic serial_in,
    output logic cts_n,
    output logic dsr_n,
    output logic ri_n,
    output logic dcd_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    initial begin
        serial_in = 1'b1;
        {cts_n, dsr_n, ri_n, dcd_n} = 4'hF;
    end
    task automatic set_cts(input logic v);
        cts_n <= v;
    endtask
    // Start bit, data LSB first, optional parity, one stop bit, then idle high
    task automatic send(input logic [7:0] v, input int nb, input logic pen, input logic par, input logic stp);
        serial_in = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < nb; i++) begin
            serial_in = v[i];
            #(BIT_NS);
        end
        if (pen) begin
            serial_in = par;
            #(BIT_NS);
        end
        serial_in = stp;
        #(BIT_NS);
        serial_in = 1'b1;
    endtask
    task automatic glitch(input int ns);
        serial_in = 1'b0;
        #(ns);
        serial_in = 1'b1;
    endtask
    // Centre sampling; only 8-bit characters are decoded
    always @(negedge serial_out) begin
        #(BIT_NS / 2);
        if (!serial_out) begin
            for (int i = 0; i < 8; i++) begin
                #(BIT_NS);
                sh[i] = serial_out;
            end
            rx_q.push_back(sh);
        end
    end
endmodule // ascu_line_model

// >>> async_serial_channel_tb.sv
// Self-checking bench: host register accesses against the line model
`include "ascu_defines.vh"
module async_serial_channel_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] o_dat = `ASCU_OFS_DATA, o_ien = `ASCU_OFS_IEN, o_iid = `ASCU_OFS_IID;
    localparam logic [2:0] o_lct = `ASCU_OFS_LCTL, o_lst = `ASCU_OFS_LSTAT, o_mst = `ASCU_OFS_MSTAT;
    logic sys_clk, rst_n, host_cs, host_rd, host_wr, ext_clock_in, serial_in, serial_out, host_data_bus_oe;
    logic cts_n, dsr_n, ri_n, dcd_n, rts_n, dtr_n, out1_n, out2_n, irq_output;
    logic [2:0] host_addr;
    logic [7:0] host_data_bus_in, host_data_bus_out, d;
    int n_fail = 0, comparisons = 0, cycles = 0;
    ascu_channel DUT (.sys_clk, .rst_n, .host_cs, .host_rd, .host_wr, .host_addr, .host_data_bus_in,
        .host_data_bus_out, .host_data_bus_oe, .ext_clock_in, .serial_in, .serial_out, .cts_n, .dsr_n,
        .ri_n, .dcd_n, .rts_n, .dtr_n, .out1_n, .out2_n, .irq_output);
    ascu_line_model u_line (.serial_out, .serial_in, .cts_n, .dsr_n, .ri_n, .dcd_n);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Baud source at half the system rate: divisor 1 gives one tick per 100 ns
    initial begin
        ext_clock_in = 1'b0;
        forever #50 ext_clock_in = ~ext_clock_in;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        host_cs <= 1'b1;
        host_wr <= 1'b1;
        host_addr <= a;
        host_data_bus_in <= v;
        @(posedge sys_clk);
        host_cs <= 1'b0;
        host_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge sys_clk);
        host_cs <= 1'b1;
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge sys_clk);
        host_cs <= 1'b0;
        host_rd <= 1'b0;
        #1 d = host_data_bus_out;
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] exp, input string nm);
        rd(a);
        chk(nm, d, exp);
    endtask
    // Bounded wait on line status bits
    task automatic poll(input logic [7:0] m, input logic [7:0] v);
        int n = 0;
        do rd(o_lst); while ((d & m) !== v && ++n < 3000);
        chk("line status wait", d & m, v);
    endtask
    task automatic reset_dut();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask
    initial begin
        {rst_n, host_cs, host_rd, host_wr, host_addr, host_data_bus_in} = 15'h0000;
        reset_dut();
        rc(o_lst, 8'h60, "status after reset");
        wr(o_lct, 8'h83);
        wr(o_dat, 8'h01);
        wr(o_ien, 8'h00);
        wr(o_lct, 8'h03);
        wr(`ASCU_OFS_MCTL, 8'h00);
        rc(o_iid, 8'h01, "ident idle");
        wr(o_ien, 8'hF2);
        rc(o_iid, 8'h02, "ident tx empty");
        chk("irq level", {7'h00, irq_output}, 8'h01);
        rc(o_iid, 8'h01, "ident serviced");
        wr(o_dat, 8'hA5);
        poll(8'h20, 8'h20);
        wr(o_dat, 8'h3C);
        rc(o_lst, 8'h00, "both empties low");
        rc(o_iid, 8'h01, "tx empty cleared by write");
        poll(8'h20, 8'h20);
        rc(o_iid, 8'h02, "tx empty again");
        poll(8'h60, 8'h60);
        chk("tx char 1", u_line.rx_q[0], 8'hA5);
        chk("tx char 2", u_line.rx_q[1], 8'h3C);
        wr(o_ien, 8'h01);
        u_line.send(8'h5A, 8, 1'b0, 1'b0, 1'b1);
        rc(o_iid, 8'h04, "ident rx data");
        rc(o_dat, 8'h5A, "rx char");
        rc(o_lst, 8'h60, "data ready cleared");
        wr(o_ien, 8'h05);
        u_line.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
        u_line.send(8'h22, 8, 1'b0, 1'b0, 1'b1);
        rc(o_iid, 8'h06, "ident line status");
        wr(o_ien, 8'h00);
        repeat (4) @(posedge sys_clk);
        rc(o_iid, 8'h01, "ident masked");
        chk("irq masked", {7'h00, irq_output}, 8'h00);
        wr(o_ien, 8'h05);
        rc(o_lst, 8'h63, "overrun");
        rc(o_iid, 8'h04, "ident after status read");
        rd(o_dat);
        for (int w = 0; w < 4; w++) begin
            wr(o_lct, 8'(w));
            u_line.send(8'hFF, 5 + w, 1'b0, 1'b0, 1'b1);
            rc(o_dat, 8'hFF >> (3 - w), "char length");
        end
        wr(o_lct, 8'h1B);
        u_line.send(8'h03, 8, 1'b1, 1'b0, 1'b1);
        rc(o_lst, 8'h61, "good parity");
        rc(o_dat, 8'h03, "parity char");
        u_line.send(8'h01, 8, 1'b1, 1'b0, 1'b1);
        rc(o_lst, 8'h65, "parity error");
        rd(o_dat);
        wr(o_lct, 8'h03);
        u_line.send(8'h0F, 8, 1'b0, 1'b0, 1'b0);
        rd(o_lst);
        chk("framing error", d & 8'h08, 8'h08);
        // Flush anything a low stop bit may have started
        repeat (800) @(posedge sys_clk);
        rd(o_lst);
        rd(o_dat);
        u_line.glitch(300);
        repeat (400) @(posedge sys_clk);
        rc(o_lst, 8'h60, "noise ignored");
        wr(o_ien, 8'h08);
        u_line.set_cts(1'b0);
        repeat (4) @(posedge sys_clk);
        rc(o_iid, 8'h00, "ident modem");
        rc(o_mst, 8'h11, "modem delta");
        rc(o_iid, 8'h01, "ident modem serviced");
        reset_dut();
        rc(o_lct, 8'h03, "line control kept");
        wr(o_lct, 8'h83);
        rc(o_dat, 8'h01, "divisor kept");
        wr(o_lct, 8'h03);
        rc(o_lst, 8'h60, "status after second reset");
        end_sim();
    end
endmodule // async_serial_channel_tb
